// >>> rtl/tca_pkg.sv
// constants for the time, calendar and alarm core
// assumes a 20 MHz system clock and an APB master with 32-bit data
package tca_pkg;

	// ----------------------------------------------------------------
	// register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_SEC = 6'h00;
	localparam logic [5:0] IDX_MIN = 6'h01;
	localparam logic [5:0] IDX_HOUR = 6'h02;
	localparam logic [5:0] IDX_WEEK = 6'h03;
	localparam logic [5:0] IDX_DATE = 6'h04;
	localparam logic [5:0] IDX_MONTH = 6'h05;
	localparam logic [5:0] IDX_YEAR = 6'h06;
	localparam logic [5:0] IDX_ALM_MIN = 6'h08;
	localparam logic [5:0] IDX_ALM_HOUR = 6'h09;
	localparam logic [5:0] IDX_ALM_WD = 6'h0A;
	localparam logic [5:0] IDX_TMR_LO = 6'h0B;
	localparam logic [5:0] IDX_TMR_HI = 6'h0C;
	localparam logic [5:0] IDX_EXT = 6'h0D;
	localparam logic [5:0] IDX_FLAG = 6'h0E;
	localparam logic [5:0] IDX_CTRL = 6'h0F;

	// ----------------------------------------------------------------
	// field positions and writable masks
	// ----------------------------------------------------------------
	localparam int ALM_OFF_BIT = 7;
	localparam int EXT_WDS_BIT = 6;
	localparam int EXT_RUN_BIT = 4;
	localparam int EXT_TSEL_LSB = 0;
	localparam int FLG_TF_BIT = 4;
	localparam int FLG_AF_BIT = 3;
	localparam int CTL_TIE_BIT = 4;
	localparam int CTL_AIE_BIT = 3;
	localparam logic [7:0] SEC_MASK = 8'h7F;
	localparam logic [7:0] MIN_MASK = 8'h7F;
	localparam logic [7:0] HOUR_MASK = 8'h3F;
	localparam logic [7:0] WEEK_MASK = 8'h7F;
	localparam logic [7:0] DATE_MASK = 8'h3F;
	localparam logic [7:0] MONTH_MASK = 8'h1F;
	localparam logic [7:0] EXT_MASK = 8'h7F;
	localparam logic [7:0] FLAG_MASK = 8'h18;
	localparam logic [7:0] CTRL_MASK = 8'h18;

	// ----------------------------------------------------------------
	// counting limits and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] SEC_LAST = 8'h59;
	localparam logic [7:0] HOUR_LAST = 8'h23;
	localparam logic [7:0] MONTH_LAST = 8'h12;
	localparam logic [7:0] YEAR_LAST = 8'h99;
	localparam logic [7:0] DATE_LONG = 8'h31;
	localparam logic [7:0] DATE_SHORT = 8'h30;
	localparam logic [7:0] FEB_NORMAL = 8'h28;
	localparam logic [7:0] FEB_LEAP = 8'h29;
	localparam logic [7:0] MONTH_FEB = 8'h02;
	localparam logic [7:0] FIRST_ONE = 8'h01;
	localparam logic [7:0] WEEK_LAST = 8'h40;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_YEAR = 8'h01;
	localparam logic [1:0] TSEL_4096 = 2'h0;
	localparam logic [1:0] TSEL_64 = 2'h1;
	localparam logic [1:0] TSEL_SEC = 2'h2;
	localparam logic [11:0] TMR_ONE = 12'h001;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int DIV_W = 25;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SEC_PERIOD_NS = 1000000000;
	localparam int TICK4096_PERIOD_NS = 244140;
	localparam int TICK64_PERIOD_NS = 15625000;
	localparam int SEC_CYCLES = SEC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICK4096_CYCLES = TICK4096_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICK64_CYCLES = TICK64_PERIOD_NS / CLK_PERIOD_NS;

endpackage

// >>> rtl/tca_core.sv
// time, calendar, alarm and countdown timer core with an APB register slave
// assumes a synchronous APB master on CLK_I; all inputs synchronous to CLK_I
//
// What this block does
// - seconds count BCD 00 to 59, wrap to 00, carry into minutes
// - minutes count BCD 00 to 59, wrap to 00, carry into hours
// - hours count BCD 00 to 23, wrap to 00, carry into day
// - unused time and calendar bits ignore writes and read zero
// - weekday is one-hot in bits 0-6, rotates left, 40h returns to 01h
// - weekday 01h is Sunday up to 40h Saturday
// - calendar sequences correctly from 2001 through 2099
// - date, month and year hold BCD, one digit per nibble
// - date wraps after 31 or 30 depending on month, back to 01
// - February wraps after 28, or after 29 in leap years
// - year value multiple of four, including 00, is a leap year
// - month counts BCD 01 to 12, wraps to 01, carries into year
// - year counts BCD 00 to 99 then wraps to 00
// - alarm compares minute, hour and either weekday mask or date
// - alarm match sets alarm flag and drives interrupt low
// - timer preset is 12 bits: low byte plus low nibble of timer high register
// - select bit one compares date, zero compares weekday mask
// - timer run starts countdown; a tick at 001h sets flag, interrupt low, and reloads the preset
// - flags stay one until host writes zero; writing one does nothing
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps

module tca_core #(
	parameter int SEC_CYCLES = tca_pkg::SEC_CYCLES,
	parameter int TICK4096_CYCLES = tca_pkg::TICK4096_CYCLES,
	parameter int TICK64_CYCLES = tca_pkg::TICK64_CYCLES
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	output logic INT_N_O
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic int_n;
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] week;
		logic [7:0] date;
		logic [7:0] month;
		logic [7:0] year;
		logic [7:0] alm_min;
		logic [7:0] alm_hour;
		logic [7:0] alm_wd;
		logic [7:0] tmr_lo;
		logic [7:0] tmr_hi;
		logic [7:0] ext;
		logic [7:0] flg;
		logic [7:0] ctl;
		logic [11:0] tmr_cnt;
		logic run_q;
		logic alarm_chk;
		logic [tca_pkg::DIV_W-1:0] sec_div;
		logic [tca_pkg::DIV_W-1:0] div4096;
		logic [tca_pkg::DIV_W-1:0] div64;
	} tca_state_t;

	tca_state_t st;
	tca_state_t next_st;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
		end else begin
			bcd_inc = 8'(v + 8'h01);
		end
	endfunction

	// tens even needs units 0/4/8, tens odd needs units 2/6
	function automatic logic is_leap(input logic [7:0] y);
		is_leap = (y[1:0] == {y[4], 1'b0});
	endfunction

	function automatic logic [7:0] date_last(input logic [7:0] m, input logic [7:0] y);
		case (m)
			tca_pkg::MONTH_FEB: date_last = is_leap(y) ? tca_pkg::FEB_LEAP : tca_pkg::FEB_NORMAL;
			8'h04, 8'h06, 8'h09, 8'h11: date_last = tca_pkg::DATE_SHORT;
			default: date_last = tca_pkg::DATE_LONG;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// bus decode and tick chain
	// ----------------------------------------------------------------
	logic [5:0] idx;
	logic mapped;
	logic access;
	logic wr;
	logic wr_ok;
	logic [7:0] wdat;
	logic sec_tick;
	logic t4096;
	logic t64;
	logic sec_wrap;
	logic min_wrap;
	logic hour_wrap;
	logic date_wrap;
	logic month_wrap;
	logic run;
	logic tmr_tick;
	logic alarm_match;
	logic wd_hit;
	logic [7:0] rd_byte;

	assign idx = PADDR_I[7:2];
	assign mapped = (PADDR_I[1:0] == 2'h0) && (idx <= tca_pkg::IDX_CTRL) && (idx != 6'h07);
	assign access = PSEL_I && PENABLE_I;
	assign wr = access && st.pready && PWRITE_I;
	assign wr_ok = wr && mapped;
	assign wdat = PWDATA_I[7:0];

	assign sec_tick = (st.sec_div == tca_pkg::DIV_W'(SEC_CYCLES - 1));
	assign t4096 = (st.div4096 == tca_pkg::DIV_W'(TICK4096_CYCLES - 1));
	assign t64 = (st.div64 == tca_pkg::DIV_W'(TICK64_CYCLES - 1));
	assign sec_wrap = sec_tick && (st.sec == tca_pkg::SEC_LAST);
	assign min_wrap = sec_wrap && (st.min == tca_pkg::SEC_LAST);
	assign hour_wrap = min_wrap && (st.hour == tca_pkg::HOUR_LAST);
	assign date_wrap = hour_wrap && (st.date == date_last(st.month, st.year));
	assign month_wrap = date_wrap && (st.month == tca_pkg::MONTH_LAST);

	// source tick for the countdown
	assign run = st.ext[tca_pkg::EXT_RUN_BIT];
	always_comb begin
		case (st.ext[tca_pkg::EXT_TSEL_LSB +: 2])
			tca_pkg::TSEL_4096: tmr_tick = t4096;
			tca_pkg::TSEL_64: tmr_tick = t64;
			tca_pkg::TSEL_SEC: tmr_tick = sec_tick;
			default: tmr_tick = sec_wrap;
		endcase
	end

	// disabled fields always count as matching
	assign wd_hit = st.ext[tca_pkg::EXT_WDS_BIT] ?
		(st.alm_wd[5:0] == st.date[5:0]) :
		((st.alm_wd[6:0] & st.week[6:0]) != 7'h00);
	assign alarm_match = (st.alm_min[tca_pkg::ALM_OFF_BIT] || st.alm_min[6:0] == st.min[6:0])
		&& (st.alm_hour[tca_pkg::ALM_OFF_BIT] || st.alm_hour[5:0] == st.hour[5:0])
		&& (st.alm_wd[tca_pkg::ALM_OFF_BIT] || wd_hit);

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		case (idx)
			tca_pkg::IDX_SEC: rd_byte = st.sec;
			tca_pkg::IDX_MIN: rd_byte = st.min;
			tca_pkg::IDX_HOUR: rd_byte = st.hour;
			tca_pkg::IDX_WEEK: rd_byte = st.week;
			tca_pkg::IDX_DATE: rd_byte = st.date;
			tca_pkg::IDX_MONTH: rd_byte = st.month;
			tca_pkg::IDX_YEAR: rd_byte = st.year;
			tca_pkg::IDX_ALM_MIN: rd_byte = st.alm_min;
			tca_pkg::IDX_ALM_HOUR: rd_byte = st.alm_hour;
			tca_pkg::IDX_ALM_WD: rd_byte = st.alm_wd;
			tca_pkg::IDX_TMR_LO: rd_byte = st.tmr_lo;
			tca_pkg::IDX_TMR_HI: rd_byte = st.tmr_hi;
			tca_pkg::IDX_EXT: rd_byte = st.ext;
			tca_pkg::IDX_FLAG: rd_byte = st.flg;
			tca_pkg::IDX_CTRL: rd_byte = st.ctl;
			default: rd_byte = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;

		// bus: one wait state, answer on the second access cycle
		next_st.pready = access && !st.pready;
		next_st.pslverr = access && !st.pready && !mapped;
		if (access && !st.pready) begin
			next_st.prdata = {24'h000000, (mapped ? rd_byte : 8'h00)};
		end

		// prescalers
		next_st.sec_div = sec_tick ? '0 : tca_pkg::DIV_W'(st.sec_div + 1'b1);
		next_st.div4096 = t4096 ? '0 : tca_pkg::DIV_W'(st.div4096 + 1'b1);
		next_st.div64 = t64 ? '0 : tca_pkg::DIV_W'(st.div64 + 1'b1);

		// time and calendar carry chain, BCD except the one-hot weekday
		if (sec_tick) begin
			next_st.sec = sec_wrap ? tca_pkg::RST_ZERO : bcd_inc(st.sec);
		end
		if (sec_wrap) begin
			next_st.min = min_wrap ? tca_pkg::RST_ZERO : bcd_inc(st.min);
		end
		if (min_wrap) begin
			next_st.hour = hour_wrap ? tca_pkg::RST_ZERO : bcd_inc(st.hour);
		end
		if (hour_wrap) begin
			next_st.week = {1'b0, st.week[5:0], st.week[6]};
			next_st.date = date_wrap ? tca_pkg::FIRST_ONE : bcd_inc(st.date);
		end
		if (date_wrap) begin
			next_st.month = month_wrap ? tca_pkg::FIRST_ONE : bcd_inc(st.month);
		end
		if (month_wrap) begin
			next_st.year = (st.year == tca_pkg::YEAR_LAST) ? tca_pkg::RST_ZERO :
				bcd_inc(st.year);
		end

		// alarm is compared once against the freshly updated minute
		next_st.alarm_chk = sec_wrap;

		// countdown timer
		next_st.run_q = run;
		if (run && !st.run_q) begin
			next_st.tmr_cnt = {st.tmr_hi[3:0], st.tmr_lo};
		end else if (run && tmr_tick) begin
			if (st.tmr_cnt == tca_pkg::TMR_ONE) begin
				next_st.tmr_cnt = {st.tmr_hi[3:0], st.tmr_lo};
			end else if (st.tmr_cnt != 12'h000) begin
				next_st.tmr_cnt = 12'(st.tmr_cnt - 12'h001);
			end
		end

		// register writes win over the counter update of the same edge
		if (wr_ok) begin
			case (idx)
				tca_pkg::IDX_SEC: begin
					next_st.sec = wdat & tca_pkg::SEC_MASK;
					next_st.sec_div = '0;
				end
				tca_pkg::IDX_MIN: next_st.min = wdat & tca_pkg::MIN_MASK;
				tca_pkg::IDX_HOUR: next_st.hour = wdat & tca_pkg::HOUR_MASK;
				tca_pkg::IDX_WEEK: next_st.week = wdat & tca_pkg::WEEK_MASK;
				tca_pkg::IDX_DATE: next_st.date = wdat & tca_pkg::DATE_MASK;
				tca_pkg::IDX_MONTH: next_st.month = wdat & tca_pkg::MONTH_MASK;
				tca_pkg::IDX_YEAR: next_st.year = wdat;
				tca_pkg::IDX_ALM_MIN: next_st.alm_min = wdat;
				tca_pkg::IDX_ALM_HOUR: next_st.alm_hour = wdat;
				tca_pkg::IDX_ALM_WD: next_st.alm_wd = wdat;
				tca_pkg::IDX_TMR_LO: next_st.tmr_lo = wdat;
				tca_pkg::IDX_TMR_HI: next_st.tmr_hi = wdat;
				tca_pkg::IDX_EXT: next_st.ext = wdat & tca_pkg::EXT_MASK;
				tca_pkg::IDX_FLAG: next_st.flg = st.flg & wdat & tca_pkg::FLAG_MASK;
				tca_pkg::IDX_CTRL: next_st.ctl = wdat & tca_pkg::CTRL_MASK;
				default: next_st.flg = st.flg;
			endcase
		end

		// flag sets come last so an event beats a clearing write
		if (st.alarm_chk && alarm_match) begin
			next_st.flg[tca_pkg::FLG_AF_BIT] = 1'b1;
		end
		if (run && st.run_q && tmr_tick && st.tmr_cnt == tca_pkg::TMR_ONE) begin
			next_st.flg[tca_pkg::FLG_TF_BIT] = 1'b1;
		end

		// interrupt low while an enabled flag stands
		next_st.int_n = !((next_st.flg[tca_pkg::FLG_AF_BIT] && next_st.ctl[tca_pkg::CTL_AIE_BIT])
			|| (next_st.flg[tca_pkg::FLG_TF_BIT] && next_st.ctl[tca_pkg::CTL_TIE_BIT]));
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st <= '0;
			st.int_n <= 1'b1;
			st.week <= tca_pkg::FIRST_ONE;
			st.date <= tca_pkg::FIRST_ONE;
			st.month <= tca_pkg::FIRST_ONE;
			st.year <= tca_pkg::RST_YEAR;
		end else begin
			st <= next_st;
		end
	end

	assign PRDATA_O = st.prdata;
	assign PREADY_O = st.pready;
	assign PSLVERR_O = st.pslverr;
	assign INT_N_O = st.int_n;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	chk_sec_wrap: assert property (
		(sec_tick && st.sec == tca_pkg::SEC_LAST && !wr) |=> (st.sec == tca_pkg::RST_ZERO))
		else $error("seconds did not wrap to zero");

	chk_min_carry: assert property (
		(sec_wrap && st.min != tca_pkg::SEC_LAST && !wr) |=> (st.min == bcd_inc($past(st.min))))
		else $error("minute carry missing");

	chk_hour_wrap: assert property (
		(min_wrap && st.hour == tca_pkg::HOUR_LAST && !wr)
		|=> (st.hour == tca_pkg::RST_ZERO && st.week != $past(st.week)))
		else $error("hour wrap or day carry wrong");

	chk_unused_zero: assert property (
		((st.sec & ~tca_pkg::SEC_MASK) == 8'h00) && ((st.hour & ~tca_pkg::HOUR_MASK) == 8'h00)
		&& ((st.date & ~tca_pkg::DATE_MASK) == 8'h00) && ((st.month & ~tca_pkg::MONTH_MASK) == 8'h00))
		else $error("unused bit not zero");

	chk_week_rot: assert property (
		(hour_wrap && st.week == tca_pkg::WEEK_LAST && !wr) |=> (st.week == tca_pkg::FIRST_ONE))
		else $error("weekday did not return to first");

	chk_feb_leap: assert property (
		(hour_wrap && st.month == tca_pkg::MONTH_FEB && st.date == tca_pkg::FEB_NORMAL && !wr)
		|=> (st.date == (is_leap(st.year) ? tca_pkg::FEB_LEAP : tca_pkg::FIRST_ONE)))
		else $error("february end wrong");

	chk_year_step: assert property (
		(date_wrap && st.month == tca_pkg::MONTH_LAST && !wr)
		|=> (st.month == tca_pkg::FIRST_ONE && st.year != $past(st.year)))
		else $error("month wrap or year carry wrong");

	chk_year_wrap: assert property (
		(month_wrap && st.year == tca_pkg::YEAR_LAST && !wr) |=> (st.year == tca_pkg::RST_ZERO))
		else $error("year did not wrap");

	chk_timer_fire: assert property (
		(run && st.run_q && tmr_tick && st.tmr_cnt == tca_pkg::TMR_ONE)
		|=> (st.flg[tca_pkg::FLG_TF_BIT] && (INT_N_O == !st.ctl[tca_pkg::CTL_TIE_BIT])))
		else $error("timer expiry not flagged");

	chk_flag_hold: assert property (
		(st.flg[tca_pkg::FLG_AF_BIT] && !(wr_ok && idx == tca_pkg::IDX_FLAG
		&& !wdat[tca_pkg::FLG_AF_BIT])) |=> st.flg[tca_pkg::FLG_AF_BIT])
		else $error("alarm flag dropped without clearing write");

	chk_alarm_int: assert property (
		(st.alarm_chk && alarm_match && st.ctl[tca_pkg::CTL_AIE_BIT] && !wr)
		|=> (st.flg[tca_pkg::FLG_AF_BIT] && !INT_N_O))
		else $error("alarm match did not raise interrupt");

	chk_short_month: assert property (
		(hour_wrap && st.date == tca_pkg::DATE_SHORT && !wr && (st.month == 8'h04
		|| st.month == 8'h06 || st.month == 8'h09 || st.month == 8'h11))
		|=> (st.date == tca_pkg::FIRST_ONE))
		else $error("short month did not wrap after the thirtieth");

	chk_leap_end: assert property (
		(hour_wrap && st.month == tca_pkg::MONTH_FEB && st.date == tca_pkg::FEB_LEAP && !wr)
		|=> (st.date == tca_pkg::FIRST_ONE && st.month == 8'h03))
		else $error("leap february end wrong");

	chk_date_miss: assert property (
		(st.alarm_chk && st.ext[tca_pkg::EXT_WDS_BIT] && !st.alm_wd[tca_pkg::ALM_OFF_BIT]
		&& st.alm_wd[5:0] != st.date[5:0] && !st.flg[tca_pkg::FLG_AF_BIT])
		|=> !st.flg[tca_pkg::FLG_AF_BIT])
		else $error("date alarm fired on another date");

	chk_timer_load: assert property (
		(run && !st.run_q) |=> (st.tmr_cnt[7:0] == $past(st.tmr_lo)
		&& st.tmr_cnt[11:8] == $past(st.tmr_hi[3:0])))
		else $error("timer did not load the preset");

endmodule // tca_core

// >>> verification/tca_testbench.sv
// self-checking bench for the time, calendar, alarm and timer core
// assumes tca_pkg and tca_core are compiled first; drives the APB slave directly
`timescale 1ns/1ps

module testbench;
	// ----------------------------------------------------------------
	// signals and byte addresses
	// ----------------------------------------------------------------
	logic clk;
	logic rst_n;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic int_n;
	int n_mismatch = 0;
	int total_checks = 0;
	localparam logic [7:0] A_SEC = {tca_pkg::IDX_SEC, 2'b00};
	localparam logic [7:0] A_MIN = {tca_pkg::IDX_MIN, 2'b00};
	localparam logic [7:0] A_HOUR = {tca_pkg::IDX_HOUR, 2'b00};
	localparam logic [7:0] A_WEEK = {tca_pkg::IDX_WEEK, 2'b00};
	localparam logic [7:0] A_DATE = {tca_pkg::IDX_DATE, 2'b00};
	localparam logic [7:0] A_MONTH = {tca_pkg::IDX_MONTH, 2'b00};
	localparam logic [7:0] A_YEAR = {tca_pkg::IDX_YEAR, 2'b00};
	localparam logic [7:0] A_AMIN = {tca_pkg::IDX_ALM_MIN, 2'b00};
	localparam logic [7:0] A_AHOUR = {tca_pkg::IDX_ALM_HOUR, 2'b00};
	localparam logic [7:0] A_AWD = {tca_pkg::IDX_ALM_WD, 2'b00};
	localparam logic [7:0] A_TLO = {tca_pkg::IDX_TMR_LO, 2'b00};
	localparam logic [7:0] A_THI = {tca_pkg::IDX_TMR_HI, 2'b00};
	localparam logic [7:0] A_EXT = {tca_pkg::IDX_EXT, 2'b00};
	localparam logic [7:0] A_FLAG = {tca_pkg::IDX_FLAG, 2'b00};
	localparam logic [7:0] A_CTRL = {tca_pkg::IDX_CTRL, 2'b00};

	typedef struct {
		logic [7:0] addr;
		logic [7:0] wd;
		logic [7:0] exp;
		logic err;
	} tca_row_t;

	tca_row_t rows [0:14] = '{
		'{A_SEC, 8'hA5, 8'h25, 1'b0},
		'{A_MIN, 8'hB7, 8'h37, 1'b0},
		'{A_HOUR, 8'hD2, 8'h12, 1'b0},
		'{A_WEEK, 8'h84, 8'h04, 1'b0},
		'{A_DATE, 8'hD5, 8'h15, 1'b0},
		'{A_MONTH, 8'hE7, 8'h07, 1'b0},
		'{A_YEAR, 8'h96, 8'h96, 1'b0},
		'{A_AMIN, 8'hAA, 8'hAA, 1'b0},
		'{A_AHOUR, 8'h5A, 8'h5A, 1'b0},
		'{A_AWD, 8'h3C, 8'h3C, 1'b0},
		'{A_TLO, 8'hA5, 8'hA5, 1'b0},
		'{A_THI, 8'hF3, 8'hF3, 1'b0},
		'{8'h1C, 8'h55, 8'h00, 1'b1},
		'{8'h01, 8'h55, 8'h00, 1'b1},
		'{8'h40, 8'h55, 8'h00, 1'b1}
	};

	tca_core #(
		.SEC_CYCLES(20),
		.TICK4096_CYCLES(5),
		.TICK64_CYCLES(8)
	) u_dut (
		.CLK_I(clk),
		.RST_N_I(rst_n),
		.PSEL_I(psel),
		.PENABLE_I(penable),
		.PWRITE_I(pwrite),
		.PADDR_I(paddr),
		.PWDATA_I(pwdata),
		.PRDATA_O(prdata),
		.PREADY_O(pready),
		.PSLVERR_O(pslverr),
		.INT_N_O(int_n)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// checking and bus tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// entered just after a rising edge; one idle cycle follows each transfer
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// registered answer is looked at mid-cycle, it stands through the next rising edge
		do begin
			@(negedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		check("pready", 32'h1, {31'h0, pready});
		rd = prdata;
		err = pslverr;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] wd);
		logic [31:0] rd;
		logic err;
		apb(1'b1, addr, wd, rd, err);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
		logic [31:0] rd;
		logic err;
		apb(1'b0, addr, 8'h00, rd, err);
		check(what, {24'h000000, exp}, rd);
	endtask

	// sets 23:59:59 on the given day, lets one second pass, reads the result
	task automatic roll(input logic [7:0] y, m, d, w, ey, em, ed, ew);
		wr(A_SEC, 8'h00);
		wr(A_YEAR, y);
		wr(A_MONTH, m);
		wr(A_DATE, d);
		wr(A_WEEK, w);
		wr(A_HOUR, 8'h23);
		wr(A_MIN, 8'h59);
		wr(A_SEC, 8'h59);
		repeat (25) @(posedge clk);
		rd_chk("sec", A_SEC, 8'h00);
		rd_chk("min", A_MIN, 8'h00);
		rd_chk("hour", A_HOUR, 8'h00);
		rd_chk("date", A_DATE, ed);
		rd_chk("month", A_MONTH, em);
		rd_chk("year", A_YEAR, ey);
		rd_chk("week", A_WEEK, ew);
	endtask

	task automatic alarm_try(input logic [7:0] ext, input logic [7:0] wd, input logic [7:0] exp);
		wr(A_EXT, ext);
		wr(A_AWD, wd);
		roll(8'h19, 8'h03, 8'h10, 8'h01, 8'h19, 8'h03, 8'h11, 8'h02);
		rd_chk("alarm flag", A_FLAG, exp);
		check("int_n alarm", (exp == 8'h00) ? 32'h1 : 32'h0, {31'h0, int_n});
		wr(A_FLAG, 8'h18);
		rd_chk("flag after one", A_FLAG, exp);
		wr(A_FLAG, 8'h00);
		rd_chk("flag after zero", A_FLAG, 8'h00);
		check("int_n cleared", 32'h1, {31'h0, int_n});
	endtask

	task automatic tmr_try(input logic [1:0] tsel, input logic [7:0] lo, input logic [7:0] hi,
			input int per);
		int p;
		int n;
		p = {20'h0, hi[3:0], lo};
		wr(A_TLO, lo);
		wr(A_THI, hi);
		wr(A_FLAG, 8'h00);
		wr(A_EXT, {6'b000100, tsel});
		n = 0;
		while (int_n !== 1'b0 && n < p * per + 4) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		check("timer span low", 32'h1, {31'h0, n >= (p - 1) * per - 2});
		check("timer span high", 32'h1, {31'h0, n < p * per + 4});
		rd_chk("timer flag", A_FLAG, 8'h10);
		wr(A_EXT, 8'h00);
		wr(A_FLAG, 8'h00);
		check("int_n timer clear", 32'h1, {31'h0, int_n});
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] rd;
		logic err;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].addr, rows[i].wd, rd, err);
			check("write error", {31'h0, rows[i].err}, {31'h0, err});
			apb(1'b0, rows[i].addr, 8'h00, rd, err);
			check("read error", {31'h0, rows[i].err}, {31'h0, err});
			check("read data", {24'h000000, rows[i].exp}, rd);
		end
		$display("test register rows done");
		roll(8'h99, 8'h12, 8'h31, 8'h40, 8'h00, 8'h01, 8'h01, 8'h01);
		roll(8'h01, 8'h02, 8'h28, 8'h01, 8'h01, 8'h03, 8'h01, 8'h02);
		roll(8'h04, 8'h02, 8'h28, 8'h02, 8'h04, 8'h02, 8'h29, 8'h04);
		roll(8'h00, 8'h02, 8'h29, 8'h04, 8'h00, 8'h03, 8'h01, 8'h08);
		roll(8'h08, 8'h04, 8'h30, 8'h08, 8'h08, 8'h05, 8'h01, 8'h10);
		roll(8'h08, 8'h01, 8'h30, 8'h10, 8'h08, 8'h01, 8'h31, 8'h20);
		roll(8'h19, 8'h09, 8'h15, 8'h20, 8'h19, 8'h09, 8'h16, 8'h40);
		$display("test calendar rollover done");
		wr(A_CTRL, 8'h08);
		wr(A_FLAG, 8'h00);
		wr(A_AMIN, 8'h00);
		wr(A_AHOUR, 8'h00);
		alarm_try(8'h00, 8'h02, 8'h08);
		alarm_try(8'h00, 8'h04, 8'h00);
		alarm_try(8'h40, 8'h11, 8'h08);
		alarm_try(8'h40, 8'h12, 8'h00);
		alarm_try(8'h40, 8'h92, 8'h08);
		$display("test alarm done");
		wr(A_CTRL, 8'h10);
		tmr_try(2'b00, 8'h02, 8'hF1, 5);
		tmr_try(2'b01, 8'h03, 8'h00, 8);
		tmr_try(2'b10, 8'h03, 8'h00, 20);
		tmr_try(2'b11, 8'h01, 8'h00, 1200);
		$display("test timer done");
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		check("int_n in reset", 32'h1, {31'h0, int_n});
		check("pready in reset", 32'h0, {31'h0, pready});
		rst_n <= 1'b1;
		@(posedge clk);
		rd_chk("sec reset", A_SEC, 8'h00);
		rd_chk("week reset", A_WEEK, 8'h01);
		rd_chk("date reset", A_DATE, 8'h01);
		rd_chk("month reset", A_MONTH, 8'h01);
		rd_chk("year reset", A_YEAR, 8'h01);
		rd_chk("flag reset", A_FLAG, 8'h00);
		$display("test reset done");
		wrap_up;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("Error watchdog expected finish seen hang");
		wrap_up;
	end
endmodule // testbench
